// *** dv/mfc_link_peer.sv ***
`default_nettype none
// ----------------------------------------
// link partner receiving our pause frames
// ----------------------------------------
module mfc_link_peer (
	input wire logic clk,
	input wire logic slow,
	input wire logic pause_req,
	output logic pause_sent,
	output logic [7:0] n_pause
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt = 4'h0;
	logic busy = 1'b0;
	initial begin
		pause_sent = 1'b0;
		n_pause = 8'h00;
	end
	// a slow peer keeps the request waiting, so the block must hold it up
	always @(posedge clk) begin
		pause_sent <= 1'b0;
		if (pause_req && !busy) begin
			cnt <= cnt + 4'h1;
			if (cnt == (slow ? 4'h8 : 4'h1)) begin
				pause_sent <= 1'b1;
				busy <= 1'b1;
				n_pause <= n_pause + 8'h01;
			end
		end else if (!pause_req) begin
			busy <= 1'b0;
			cnt <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// *** dv/mfc_top_tb_top.sv ***
`include "mfc_regs.svh"
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module mfc_top_tb_top
	import mfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, look = 1'b0, slow = 1'b1;
	logic rx_done = 1'b0, ovf = 1'b0, drop = 1'b0, link = 1'b0, phy_duplex_indication = 1'b0, rxa = 1'b0;
	logic tx_done = 1'b0, retry = 1'b0, pend = 1'b0, sent;
	logic deliver, allow, paused, preq, dup;
	logic [7:0] addr = 8'h00, n_pause;
	logic [31:0] wdata = 32'h0, rdata, rnd;
	logic [12:0] level = 13'h0;
	logic [15:0] ptime, pt;
	logic [34:0] e;
	logic [34:0] q[$];
	logic [47:0] station = 48'h001122334455;
	logic [47:0] mc = 48'h0180c2000001;
	mfc_rxf_t frame = '0;
	int n_fail = 0, n_tests = 0, np = 0;
	// outputs by selector, 0 is read data
	wire logic [7:0][31:0] outs = {32'(dup), 32'(n_pause), 32'(allow), 32'(ptime),
		32'(preq), 32'(paused), 32'(deliver), rdata};

	mfc_top dut (
		.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .STATION_ADDR(station), .RX_DONE(rx_done), .RX_FRAME(frame),
		.RX_ACTIVE(rxa), .RX_LEVEL(level), .RX_OVERFLOW(ovf), .RX_DROP(drop),
		.TX_DONE(tx_done), .TX_RETRY(retry), .TX_PEND(pend), .PAUSE_SENT(sent),
		.LINK_UP(link), .PHY_DUPLEX_INDICATION(phy_duplex_indication), .RX_DELIVER(deliver),
		.TX_ALLOW(allow), .TX_PAUSED(paused), .PAUSE_REQ(preq), .PAUSE_TIME(ptime),
		.DUPLEX_FULL(dup)
	);
	mfc_link_peer peer (.clk(clk), .slow(slow), .pause_req(preq), .pause_sent(sent),
		.n_pause(n_pause));

	always #25 clk = ~clk;

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// the watcher pairs the oldest note with the output it names
	always @(posedge clk) begin
		if (look) begin
			e = q.pop_front();
			chk(outs[e[34:32]], e[31:0]);
		end
	end
	// note a result due k edges from now; never call twice at one edge
	task automatic n(input logic [2:0] s, input logic [31:0] x, input int k);
		repeat (k) @(posedge clk);
		q.push_back({s, x});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic r(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		n(0, x, 0);
	endtask
	// x of 2 leaves delivery unchecked
	task automatic rx(input logic [47:0] d, input logic [15:0] t, o, p, input logic [1:0] x);
		@(posedge clk);
		frame <= mfc_rxf_t'({d, t, o, p});
		rx_done <= 1'b1;
		@(posedge clk);
		rx_done <= 1'b0;
		if (x < 2)
			n(1, 32'(x), 0);
	endtask
	task automatic tx(input logic p, t);
		@(posedge clk);
		pend <= p;
		retry <= t;
		tx_done <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		retry <= 1'b0;
	endtask
	task automatic kick(input logic o);
		@(posedge clk);
		ovf <= o;
		drop <= !o;
		@(posedge clk);
		ovf <= 1'b0;
		drop <= 1'b0;
	endtask

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	// main sequence
	initial begin
		void'($urandom(32'h9d99));
		rnd = $urandom;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		r(`MFC_A_STAT, 0);
		w(8'h3c, 32'hffffffff);
		r(8'h3c, 0);
		w(`MFC_A_AGAP, rnd);
		r(`MFC_A_AGAP, rnd & 32'hffff);
		// 1000 mode: adaptive 800 ns against programmed 400 ns
		w(`MFC_A_CTRL, 32'h20);
		w(`MFC_A_AGAP, 100);
		w(`MFC_A_GAP, 50);
		tx(1, 0);
		n(5, 0, 9);
		n(5, 1, 9);
		tx(0, 0);
		n(5, 1, 11);
		tx(1, 1);
		n(5, 1, 11);
		// 100 mode: 800 ns adaptive loses to the 960 ns floor
		w(`MFC_A_CTRL, 32'h10);
		w(`MFC_A_GAP, 0);
		w(`MFC_A_AGAP, 10);
		tx(1, 0);
		n(5, 0, 16);
		n(5, 1, 8);
		w(`MFC_A_AGAP, 30);
		tx(1, 0);
		n(5, 0, 39);
		n(5, 1, 15);
		// a receive between two sends drops the adaptive delay; 31 edges keep slot phase
		tx(1, 0);
		rxa <= 1'b1;
		@(posedge clk);
		rxa <= 1'b0;
		n(5, 1, 27);
		// back to the normal zero setting
		w(`MFC_A_AGAP, 0);
		// receive side pause handling
		w(`MFC_A_CADL, 32'hc2000001);
		w(`MFC_A_CADH, 32'h0180);
		w(`MFC_A_CTYP, 32'h8808);
		w(`MFC_A_CTRL, 32'h21);
		rx(mc, 16'h8808, 1, 2, 0);
		n(2, 1, 1);
		n(5, 0, 1);
		n(2, 1, 8);
		n(2, 0, 15);
		rx(mc, 16'h8808, 1, 16'hffff, 0);
		rx(mc, 16'h8808, 1, 0, 0);
		n(2, 0, 1);
		r(`MFC_A_XONC, 1);
		r(`MFC_A_XOFC, 2);
		for (int i = 0; i < 3; i++) begin
			rx(i == 0 ? ~station : mc, i == 1 ? 16'h8809 : 16'h8808, 16'(i == 2) + 1, 5, 2);
			n(2, 0, 1);
		end
		w(`MFC_A_CTRL, 32'h20);
		rx(mc, 16'h8808, 1, 5, 2);
		n(2, 0, 1);
		w(`MFC_A_CTRL, 32'h21);
		w(`MFC_A_RXC, 1);
		rx(station, 16'h8808, 1, 0, 0);
		w(`MFC_A_RXC, 2);
		rx(station, 16'h8808, 1, 0, 1);
		rx(mc, 16'h8808, 2, 0, 1);
		w(`MFC_A_RXC, 0);
		rx(mc, 16'h8808, 2, 0, 0);
		// software pause with transmit enable off; zero time first
		for (int i = 0; i < 2; i++) begin
			pt = i ? rnd[15:0] : 16'h0;
			w(`MFC_A_PTIM, 32'(pt));
			w(`MFC_A_TXC, 1);
			n(3, 1, 2);
			n(4, 32'(pt), 1);
			n(6, ++np, 12);
			r(`MFC_A_TXC, 0);
		end
		// watermark pauses, full duplex assumed
		w(`MFC_A_HIGH, 100);
		w(`MFC_A_LOW, 32'h80000014);
		w(`MFC_A_REFR, 2);
		w(`MFC_A_PTIM, 32'h33);
		level <= 13'd120;
		kick(0);
		n(6, np, 20);
		level <= 13'd0;
		w(`MFC_A_CTRL, 32'h23);
		level <= 13'd120;
		n(3, 1, 3);
		n(4, 32'h33, 1);
		// first frame plus two refreshes; the third one must be out before the drop
		np += 3;
		n(6, np, 44);
		level <= 13'd10;
		n(3, 1, 3);
		n(4, 0, 1);
		n(6, ++np, 12);
		slow <= 1'b0;
		kick(1);
		n(6, ++np, 14);
		kick(0);
		n(6, ++np, 14);
		phy_duplex_indication <= 1'b1;
		link <= 1'b1;
		n(7, 1, 3);
		w(`MFC_A_CTRL, 32'h27);
		n(7, 0, 2);
		// let the watcher finish its last compare first
		@(posedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire

// *** hw/mfc_pkg.sv ***
`default_nettype none
package mfc_pkg;
	// header fields of a finished receive frame
	typedef struct packed {
		logic [47:0] dest;
		logic [15:0] ftype;
		logic [15:0] opcode;
		logic [15:0] ptime;
	} mfc_rxf_t;
	// pause transmit request state
	typedef enum logic {
		MFC_PT_IDLE = 1'b0,
		MFC_PT_SEND = 1'b1
	} mfc_ptx_t;
endpackage
`default_nettype wire

// *** hw/mfc_regs.svh ***
`ifndef MFC_REGS_SVH
`define MFC_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MFC_A_CTRL 8'h00
`define MFC_A_STAT 8'h04
`define MFC_A_CADL 8'h08
`define MFC_A_CADH 8'h0c
`define MFC_A_CTYP 8'h10
`define MFC_A_HIGH 8'h14
`define MFC_A_LOW 8'h18
`define MFC_A_PTIM 8'h1c
`define MFC_A_REFR 8'h20
`define MFC_A_GAP 8'h24
`define MFC_A_AGAP 8'h28
`define MFC_A_RXC 8'h2c
`define MFC_A_TXC 8'h30
`define MFC_A_XONC 8'h34
`define MFC_A_XOFC 8'h38
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define MFC_B_RXEN 0
`define MFC_B_TXEN 1
`define MFC_B_FDUP 2
`define MFC_B_FVAL 3
`define MFC_F_SPD 5:4
`define MFC_B_RESUME_FRAME_ENABLE 31
`define MFC_B_DISC 0
`define MFC_B_PASS 1
`define MFC_B_SWP 0
`define MFC_SPD_10 2'h0
`define MFC_SPD_100 2'h1
`define MFC_PAUSE_OP 16'h0001
// ----------------------------------------
// timing, in ns, and derived counts
// ----------------------------------------
`define MFC_CLK_NS 50
`define MFC_SLOT_NS 512
`define MFC_SLOT_CYC ((`MFC_SLOT_NS + `MFC_CLK_NS - 1) / `MFC_CLK_NS)
`define MFC_PER10_NS 800
`define MFC_PER100_NS 80
`define MFC_PER1G_NS 8
`define MFC_MIN10_NS 9600
`define MFC_MIN100_NS 960
`define MFC_MIN1G_NS 96
`endif

// *** hw/mfc_top.sv ***
`include "mfc_regs.svh"
`default_nettype none
module mfc_top
	import mfc_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic [47:0] STATION_ADDR,
	input wire logic RX_DONE,
	input wire mfc_rxf_t RX_FRAME,
	input wire logic RX_ACTIVE,
	input wire logic [12:0] RX_LEVEL,
	input wire logic RX_OVERFLOW,
	input wire logic RX_DROP,
	input wire logic TX_DONE,
	input wire logic TX_RETRY,
	input wire logic TX_PEND,
	input wire logic PAUSE_SENT,
	input wire logic LINK_UP,
	input wire logic PHY_DUPLEX_INDICATION,
	output logic RX_DELIVER,
	output logic TX_ALLOW,
	output logic TX_PAUSED,
	output logic PAUSE_REQ,
	output logic [15:0] PAUSE_TIME,
	output logic DUPLEX_FULL
);
	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [5:0] ctrl;
	logic [31:0] cadl;
	logic [15:0] cadh;
	logic [15:0] ctyp;
	logic [12:0] high_water;
	logic [12:0] low_water;
	logic resume_frame_enable;
	logic [15:0] ptim;
	logic [15:0] refr;
	logic [9:0] gap_val;
	logic [15:0] adaptive_gap_delay;
	logic [1:0] rxc;
	logic sw_req;
	logic [15:0] xon_cnt;
	logic [15:0] xoff_cnt;
	wire wr_ctrl = WR && ADDR == `MFC_A_CTRL;
	wire wr_txc = WR && ADDR == `MFC_A_TXC;
	wire rx_en = ctrl[`MFC_B_RXEN];
	wire tx_en = ctrl[`MFC_B_TXEN];
	wire [1:0] spd = ctrl[`MFC_F_SPD];
	// plain configuration writes; software owns these words
	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl <= 6'h00;
			cadl <= 32'h00000000;
			cadh <= 16'h0000;
			ctyp <= 16'h0000;
			high_water <= 13'h0000;
			low_water <= 13'h0000;
			resume_frame_enable <= 1'b0;
			ptim <= 16'h0000;
			refr <= 16'h0000;
			gap_val <= 10'h000;
			adaptive_gap_delay <= 16'h0000;
			rxc <= 2'h0;
		end else if (WR) begin
			case (ADDR)
				`MFC_A_CTRL: ctrl <= WDATA[5:0];
				`MFC_A_CADL: cadl <= WDATA;
				`MFC_A_CADH: cadh <= WDATA[15:0];
				`MFC_A_CTYP: ctyp <= WDATA[15:0];
				`MFC_A_HIGH: high_water <= WDATA[12:0];
				`MFC_A_LOW: begin
					low_water <= WDATA[12:0];
					resume_frame_enable <= WDATA[`MFC_B_RESUME_FRAME_ENABLE];
				end
				`MFC_A_PTIM: ptim <= WDATA[15:0];
				`MFC_A_REFR: refr <= WDATA[15:0];
				`MFC_A_GAP: gap_val <= WDATA[9:0];
				`MFC_A_AGAP: adaptive_gap_delay <= WDATA[15:0];
				`MFC_A_RXC: rxc <= WDATA[1:0];
				default: ;
			endcase
		end
	end
	// read mux; unmapped offsets read as zero
	logic [31:0] rd_mux;
	always_comb begin
		case (ADDR)
			`MFC_A_CTRL: rd_mux = {26'h0, ctrl};
			`MFC_A_STAT: rd_mux = {30'h0, DUPLEX_FULL, TX_PAUSED};
			`MFC_A_CADL: rd_mux = cadl;
			`MFC_A_CADH: rd_mux = {16'h0, cadh};
			`MFC_A_CTYP: rd_mux = {16'h0, ctyp};
			`MFC_A_HIGH: rd_mux = {19'h0, high_water};
			`MFC_A_LOW: rd_mux = {resume_frame_enable, 18'h0, low_water};
			`MFC_A_PTIM: rd_mux = {16'h0, ptim};
			`MFC_A_REFR: rd_mux = {16'h0, refr};
			`MFC_A_GAP: rd_mux = {22'h0, gap_val};
			`MFC_A_AGAP: rd_mux = {16'h0, adaptive_gap_delay};
			`MFC_A_RXC: rd_mux = {30'h0, rxc};
			`MFC_A_TXC: rd_mux = {31'h0, sw_req};
			`MFC_A_XONC: rd_mux = {16'h0, xon_cnt};
			`MFC_A_XOFC: rd_mux = {16'h0, xoff_cnt};
			default: rd_mux = 32'h0;
		endcase
	end
	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK) begin
		if (RESET)
			RDATA <= 32'h0;
		else
			RDATA <= RD ? rd_mux : 32'h0;
	end
	// ----------------------------------------
	// duplex resolution
	// ----------------------------------------
	logic link_q;
	wire link_rise = LINK_UP && !link_q;
	// sample duplex at link up unless forced
	always_ff @(posedge CLK) begin
		if (RESET) begin
			link_q <= 1'b0;
			DUPLEX_FULL <= 1'b0;
		end else begin
			link_q <= LINK_UP;
			if (ctrl[`MFC_B_FDUP])
				DUPLEX_FULL <= ctrl[`MFC_B_FVAL];
			else if (link_rise)
				DUPLEX_FULL <= PHY_DUPLEX_INDICATION;
		end
	end
	// ----------------------------------------
	// receive classification
	// ----------------------------------------
	// three-way match for a pause frame
	wire to_ctl = RX_FRAME.dest == {cadh, cadl};
	wire to_sta = RX_FRAME.dest == STATION_ADDR;
	wire ctl_frame = (to_ctl || to_sta) && RX_FRAME.ftype == ctyp;
	wire is_pause = ctl_frame && RX_FRAME.opcode == `MFC_PAUSE_OP;
	wire got_xoff = RX_DONE && rx_en && is_pause && RX_FRAME.ptime != 16'h0;
	wire got_xon = RX_DONE && rx_en && is_pause && RX_FRAME.ptime == 16'h0;
	wire del_pause = to_sta && !rxc[`MFC_B_DISC];
	// pass bit delivers non-pause control frames
	wire del_ctl = rxc[`MFC_B_PASS];
	wire deliver = is_pause ? del_pause : (ctl_frame ? del_ctl : 1'b1);
	always_ff @(posedge CLK) begin
		if (RESET)
			RX_DELIVER <= 1'b0;
		else
			RX_DELIVER <= RX_DONE && deliver;
	end
	// ----------------------------------------
	// slot tick and pause timer
	// ----------------------------------------
	logic [3:0] slot_cnt;
	wire slot_tick = slot_cnt == 4'(`MFC_SLOT_CYC - 1);
	always_ff @(posedge CLK) begin
		if (RESET)
			slot_cnt <= 4'h0;
		else
			slot_cnt <= slot_tick ? 4'h0 : slot_cnt + 4'h1;
	end
	logic [15:0] pause_tmr;
	// XOFF loads timer and sets paused flag
	// XON or expiry resumes; stats count XON and XOFF frames
	// timer steps down once per slot
	always_ff @(posedge CLK) begin
		if (RESET) begin
			pause_tmr <= 16'h0;
			TX_PAUSED <= 1'b0;
			xon_cnt <= 16'h0;
			xoff_cnt <= 16'h0;
		end else if (got_xoff) begin
			pause_tmr <= RX_FRAME.ptime;
			TX_PAUSED <= 1'b1;
			xoff_cnt <= xoff_cnt + 16'h1;
		end else if (got_xon) begin
			pause_tmr <= 16'h0;
			TX_PAUSED <= 1'b0;
			xon_cnt <= xon_cnt + 16'h1;
		end else if (TX_PAUSED && pause_tmr == 16'h0) begin
			TX_PAUSED <= 1'b0;
		end else if (TX_PAUSED && slot_tick) begin
			pause_tmr <= pause_tmr - 16'h1;
		end
	end
	// ----------------------------------------
	// inter-packet gap
	// ----------------------------------------
	logic [31:0] gap_ns;
	logic b2b;
	logic [31:0] per_ns;
	logic [31:0] min_ns;
	// one transmit clock period per speed
	always_comb begin
		case (spd)
			`MFC_SPD_10: begin
				per_ns = `MFC_PER10_NS;
				min_ns = `MFC_MIN10_NS;
			end
			`MFC_SPD_100: begin
				per_ns = `MFC_PER100_NS;
				min_ns = `MFC_MIN100_NS;
			end
			default: begin
				per_ns = `MFC_PER1G_NS;
				min_ns = `MFC_MIN1G_NS;
			end
		endcase
	end
	wire [31:0] adapt_ns = 32'(adaptive_gap_delay * per_ns);
	wire [31:0] prog_ns = 32'(gap_val * per_ns);
	// larger of the two on back-to-back sends, else the programmed gap; never their sum
	wire [31:0] gap_a = (b2b && adapt_ns > prog_ns) ? adapt_ns : prog_ns;
	wire [31:0] need_ns = gap_a > min_ns ? gap_a : min_ns;
	wire gap_met = gap_ns >= need_ns;
	// adaptive delay only for back-to-back sends
	always_ff @(posedge CLK) begin
		if (RESET)
			b2b <= 1'b0;
		else if (TX_DONE)
			b2b <= TX_PEND && !TX_RETRY;
		// nothing waiting means the next send is not back-to-back
		else if (RX_ACTIVE || TX_RETRY || !TX_PEND)
			b2b <= 1'b0;
	end
	// gap timer saturates so a long idle never wraps
	always_ff @(posedge CLK) begin
		if (RESET)
			gap_ns <= 32'hffffffff;
		else if (TX_DONE || RX_ACTIVE)
			gap_ns <= 32'h0;
		else if (gap_ns < 32'hffffffff - `MFC_CLK_NS)
			gap_ns <= gap_ns + `MFC_CLK_NS;
	end
	// pause only blocks a new start; a frame in flight finishes
	always_ff @(posedge CLK) begin
		if (RESET)
			TX_ALLOW <= 1'b0;
		else
			TX_ALLOW <= gap_met && !TX_PAUSED && !got_xoff;
	end
	// ----------------------------------------
	// pause frame generation
	// ----------------------------------------
	logic above;
	logic xoff_out;
	logic sent_any;
	logic [15:0] refr_cnt;
	mfc_ptx_t pt_state;
	mfc_ptx_t next_pt_state;
	wire hi_hit = RX_LEVEL >= high_water;
	wire lo_hit = RX_LEVEL <= low_water;
	wire trig_hi = hi_hit && !above;
	// refresh expiry while still above low
	wire trig_rf = above && !lo_hit && refr_cnt == refr;
	wire trig_lo = above && lo_hit && resume_frame_enable;
	// overflow once a pause is out
	wire trig_ov = RX_OVERFLOW && sent_any;
	// automatic frames gated by transmit enable
	wire auto_go = tx_en && (trig_hi || trig_rf || trig_lo || trig_ov || RX_DROP);
	wire auto_xon = trig_lo && !trig_hi;
	always_ff @(posedge CLK) begin
		if (RESET) begin
			above <= 1'b0;
			refr_cnt <= 16'h0;
			sent_any <= 1'b0;
		end else begin
			if (trig_hi || trig_rf)
				refr_cnt <= 16'h0;
			else if (above && slot_tick)
				refr_cnt <= refr_cnt + 16'h1;
			if (trig_hi)
				above <= 1'b1;
			else if (lo_hit)
				above <= 1'b0;
			if (PAUSE_SENT)
				sent_any <= 1'b1;
		end
	end
	// software request self clears; a new write wins
	always_ff @(posedge CLK) begin
		if (RESET)
			sw_req <= 1'b0;
		else if (wr_txc && WDATA[`MFC_B_SWP])
			sw_req <= 1'b1;
		else if (PAUSE_SENT && !xoff_out)
			sw_req <= 1'b0;
	end
	always_comb begin
		next_pt_state = pt_state;
		case (pt_state)
			MFC_PT_IDLE:
				if (auto_go || sw_req)
					next_pt_state = MFC_PT_SEND;
			MFC_PT_SEND:
				if (PAUSE_SENT)
					next_pt_state = MFC_PT_IDLE;
			default: next_pt_state = MFC_PT_IDLE;
		endcase
	end
	// xoff_out marks an automatic frame, else the software one
	always_ff @(posedge CLK) begin
		if (RESET) begin
			pt_state <= MFC_PT_IDLE;
			xoff_out <= 1'b0;
			PAUSE_TIME <= 16'h0;
		end else begin
			pt_state <= next_pt_state;
			if (pt_state == MFC_PT_IDLE && auto_go) begin
				xoff_out <= 1'b1;
				PAUSE_TIME <= auto_xon ? 16'h0 : ptim;
			end else if (pt_state == MFC_PT_IDLE && sw_req) begin
				xoff_out <= 1'b0;
				PAUSE_TIME <= ptim;
			end
		end
	end
	always_ff @(posedge CLK) begin
		if (RESET)
			PAUSE_REQ <= 1'b0;
		else
			PAUSE_REQ <= next_pt_state == MFC_PT_SEND && !PAUSE_SENT;
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_xoff;
		got_xoff;
	endsequence
	pause_set_a: assert property (s_xoff |=> TX_PAUSED)
		else $error("xoff did not pause");
	xon_clear_a: assert property (got_xon && !got_xoff |=> !TX_PAUSED)
		else $error("xon did not resume");
	xon_count_a: assert property (got_xon |=> xon_cnt == $past(xon_cnt) + 16'h1)
		else $error("xon not counted");
	rx_gate_a: assert property (!rx_en |-> !got_xoff && !got_xon)
		else $error("pause acted while disabled");
	tmr_expire_a: assert property (TX_PAUSED && pause_tmr == 16'h0 && !got_xoff
		|=> !TX_PAUSED)
		else $error("timer expiry missed");
	gap_min_a: assert property (TX_ALLOW |-> $past(gap_ns) >= $past(min_ns))
		else $error("start before minimum gap");
	paused_block_a: assert property (TX_PAUSED |-> !TX_ALLOW)
		else $error("allowed while paused");
	auto_gate_a: assert property (!tx_en && !sw_req && pt_state == MFC_PT_IDLE
		|=> pt_state == MFC_PT_IDLE)
		else $error("auto pause without enable");
	sw_go_a: assert property (sw_req && pt_state == MFC_PT_IDLE
		|=> pt_state == MFC_PT_SEND ##1 PAUSE_REQ)
		else $error("software pause not issued");
	disc_a: assert property (RX_DONE && is_pause && to_sta && rxc[`MFC_B_DISC]
		|=> !RX_DELIVER)
		else $error("discarded pause delivered");
	pass_a: assert property (RX_DONE && ctl_frame && !is_pause
		|=> RX_DELIVER == $past(rxc[`MFC_B_PASS]))
		else $error("control frame pass wrong");
	sum_a: assert property (b2b && adapt_ns >= prog_ns && adapt_ns >= min_ns
		|-> need_ns == adapt_ns)
		else $error("gap is a sum");
endmodule
`default_nettype wire
